// ==== dv/power_mode_controller_bench.sv ====
// Self-checking bench for the power mode controller
`timescale 1ns/100ps
module power_mode_controller_bench;
    import pmc_pkg::*;
    // ==========================================
    // Stimulus and observed signals
    logic core_clk = 1'b0; // Bench clock
    logic reset_n = 1'b0; // Active-low reset
    reg_req_t req = '0; // Register request
    logic [7:0] reg_rdata; // Read data
    logic irq_pending = 1'b0; // Any interrupt
    wake_src_t wake_src = '0; // Wake sources
    logic comparator0_out = 1'b1; // Comparator level, idles high
    logic external_reset_pin_n = 1'b1; // Reset pin
    logic power_on_reset = 1'b0; // Power-on reset
    logic other_reset = 1'b0; // Any other reset source
    power_ctrl_t power_ctrl; // Clock and bias controls
    logic [7:0] periph_clk_gate; // Gated peripheral clocks
    logic [1:0] system_clock_sel; // Clock source
    logic reset_request; // Reset request
    power_mode_t power_mode; // Current mode
    int err_count = 0; // Mismatches
    int n_checks = 0; // Comparisons
    int cycles = 0; // Timeout counter
    integer seed = 32'h799d; // Fixed seed
    logic [7:0] en, rg, v; // Random register values
    logic dp, expq; // Depth select, request expected
    int i, s, k; // Loop indices
    power_mode_t m; // Mode under test

    // ==========================================
    // Device under test
    power_mode_controller uut (
        .core_clk(core_clk), .reset_n(reset_n), .reg_req(req), .reg_rdata(reg_rdata),
        .irq_pending(irq_pending), .wake_src(wake_src), .comparator0_out(comparator0_out),
        .external_reset_pin_n(external_reset_pin_n), .power_on_reset(power_on_reset),
        .other_reset(other_reset), .power_ctrl(power_ctrl), .periph_clk_gate(periph_clk_gate),
        .system_clock_sel(system_clock_sel), .reset_request(reset_request), .power_mode(power_mode)
    );

    // Clock of 5 ns period
    always #2.5 core_clk = ~core_clk;

    // Cut a hang short
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            stop_test();
        end
    end

    // ==========================================
    // Helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic chk_mode(input power_mode_t e);
        chk(8'(power_mode), 8'(e), "mode");
    endtask : chk_mode

    // Expected controls as {mask, value}; undefined fields are masked out
    function automatic logic [15:0] ctrl_exp(input power_mode_t e, input logic [7:0] r);
        case (e)
            MODE_NORMAL: return {8'hf3, 8'hf0};
            MODE_IDLE: return {8'hf3, 8'h70};
            MODE_SUSPEND: return {8'hff, 4'h0, r[1], r[2], 2'b00};
            MODE_SNOOZE: return {8'hff, 4'h0, r[1], r[2], 2'b10};
            default: return {8'hf1, 8'h01};
        endcase
    endfunction : ctrl_exp

    task automatic chk_ctrl(input power_mode_t e, input logic [7:0] r);
        logic [15:0] x;
        x = ctrl_exp(e, r);
        chk(power_ctrl & x[15:8], x[7:0], "controls");
    endtask : chk_ctrl

    // One-cycle write, taken at the second edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk) req.wr <= 1'b0;
        #1;
    endtask : wr

    // One-cycle read, data checked in the cycle after
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk) req.rd <= 1'b0;
        #1;
        chk(reg_rdata, e, "read data");
    endtask : rd_chk

    // Bounded wait for a mode
    task automatic wait_mode(input power_mode_t e);
        for (int j = 0; j < 8 && power_mode !== e; j++) begin
            @(posedge core_clk);
            #1;
        end
        chk_mode(e);
    endtask : wait_mode

    task automatic do_reset(input int n);
        @(posedge core_clk) reset_n <= 1'b0;
        repeat (n) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
    endtask : do_reset

    task automatic stop_test();
        $display("checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    // ==========================================
    // Main sequence
    initial begin
        do_reset(20);
        chk_mode(MODE_NORMAL);
        chk_ctrl(MODE_NORMAL, 8'h00);
        rd_chk(4'h3, 8'h00);
        rd_chk(4'h2, 8'h00);
        rd_chk(4'h5, 8'h00);
        rd_chk(4'hf, 8'h00);
        v = 8'($random(seed));
        wr(4'h5, v);
        chk(8'(system_clock_sel), 8'(v[1:0]), "clock select");
        // Idle entry, refused write, interrupt wake
        for (i = 0; i < 4; i++) begin
            en = (i == 0) ? 8'hff : 8'($random(seed));
            wr(4'h3, en);
            rd_chk(4'h3, en);
            wr(4'h0, 8'h01);
            chk_mode(MODE_IDLE);
            chk_ctrl(MODE_IDLE, 8'h00);
            chk(periph_clk_gate, en, "idle gates");
            wr(4'h1, 8'h01);
            chk_mode(MODE_IDLE);
            rd_chk(4'h4, 8'h01);
            rd_chk(4'h0, 8'h01);
            @(posedge core_clk) irq_pending <= 1'b1;
            @(posedge core_clk) irq_pending <= 1'b0;
            #1;
            chk_mode(MODE_NORMAL);
            chk(periph_clk_gate, en, "normal gates");
        end
        // Suspend and snooze, each wake source, comparator edge last
        for (i = 0; i < 14; i++) begin
            s = i % 7;
            m = (i < 7) ? MODE_SUSPEND : MODE_SNOOZE;
            rg = 8'($random(seed)) & 8'h06;
            wr(4'h2, rg);
            wr(4'h5, 8'h00);
            wr(4'h1, (i < 7) ? 8'h01 : 8'h02);
            chk_mode(m);
            chk_ctrl(m, rg);
            chk(periph_clk_gate, 8'h00, "sleep gates");
            rd_chk(4'h4, 8'(m));
            rd_chk(4'h1, (i < 7) ? 8'h01 : 8'h02);
            if (s < 6) begin
                @(posedge core_clk) wake_src <= wake_src_t'(6'h20 >> s);
                @(posedge core_clk) wake_src <= '0;
                #1;
            end else begin
                @(posedge core_clk) comparator0_out <= 1'b0;
                #1;
            end
            wait_mode(MODE_NORMAL);
            chk_ctrl(MODE_NORMAL, rg);
            rd_chk(4'h1, 8'h00);
            @(posedge core_clk) comparator0_out <= 1'b1;
        end
        // Suspend wins over snooze in one write
        wr(4'h1, 8'h03);
        chk_mode(MODE_SUSPEND);
        @(posedge core_clk) wake_src <= '{timer4_event: 1'b1, default: 1'b0};
        @(posedge core_clk) wake_src <= '0;
        #1;
        wait_mode(MODE_NORMAL);
        // Stop and shutdown against each reset source
        for (i = 0; i < 6; i++) begin
            dp = (i >= 3);
            s = i % 3;
            m = dp ? MODE_SHUTDOWN : MODE_STOP;
            expq = !(dp && s == 2);
            wr(4'h2, {7'h00, dp});
            wr(4'h0, (i == 0) ? 8'h03 : 8'h02);
            chk_mode(m);
            chk_ctrl(m, 8'h00);
            rd_chk(4'h0, 8'h02);
            @(posedge core_clk) begin
                external_reset_pin_n <= (s != 0);
                power_on_reset <= (s == 1);
                other_reset <= (s == 2);
            end
            @(posedge core_clk) begin
                external_reset_pin_n <= 1'b1;
                power_on_reset <= 1'b0;
                other_reset <= 1'b0;
            end
            #1;
            for (k = 0; k < 6 && reset_request !== 1'b1; k++) begin
                @(posedge core_clk);
                #1;
            end
            chk(8'(reset_request), 8'(expq), "reset request");
            chk_mode(expq ? m : MODE_SHUTDOWN);
            do_reset(2);
            chk_mode(MODE_NORMAL);
        end
        stop_test();
    end
endmodule : power_mode_controller_bench

// ==== logic/pmc_defs.svh ====
// Constant definitions for the power mode controller
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
// Register offsets
`define PMC_ADDR_W 4
`define PMC_OFF_PRIMARY 4'h0
`define PMC_OFF_SECONDARY 4'h1
`define PMC_OFF_REGULATOR 4'h2
`define PMC_OFF_PERIPH_EN 4'h3
`define PMC_OFF_STATUS 4'h4
`define PMC_OFF_CLOCK_SRC 4'h5
// Field positions
`define PMC_BIT_IDLE 0
`define PMC_BIT_STOP 1
`define PMC_BIT_SUSPEND 0
`define PMC_BIT_SNOOZE 1
`define PMC_BIT_DEPTH 0
`define PMC_BIT_SLOW_T3 1
`define PMC_BIT_SLOW_T4 2
// Reset values
`define PMC_RST_PERIPH_EN 8'h00
`define PMC_RST_CLOCK_SRC 8'h00
`define PMC_RST_REGULATOR 8'h00
// Clock source code for the first fast oscillator
`define PMC_SRC_FAST_A 2'h0
// Number of wake sources and gated peripherals
`define PMC_WAKE_N 6
`define PMC_PERIPH_N 8
`endif

// ==== logic/pmc_pkg.sv ====
// Types shared by the power mode controller files
package pmc_pkg;
    // Power modes
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0,
        MODE_IDLE = 3'h1,
        MODE_SUSPEND = 3'h2,
        MODE_SNOOZE = 3'h3,
        MODE_STOP = 3'h4,
        MODE_SHUTDOWN = 3'h5
    } power_mode_t;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Clock, oscillator and regulator controls
    typedef struct packed {
        logic core_clk_en;
        logic periph_clk_en;
        logic fast_oscillator_a_en;
        logic fast_oscillator_b_en;
        logic slow_t3_en;
        logic slow_t4_en;
        logic reg_low_bias;
        logic power_nets_off;
    } power_ctrl_t;

    // Wake sources from suspend and snooze
    typedef struct packed {
        logic timer4_event;
        logic spi_activity;
        logic i2c_target_activity;
        logic port_match;
        logic comparator0_fall;
        logic clu_event;
    } wake_src_t;
endpackage : pmc_pkg

// ==== logic/pmc_reset_sync.sv ====
// Two-stage reset release synchroniser
`timescale 1ns/100ps
module pmc_reset_sync (
    input wire logic core_clk,
    input wire logic reset_n,
    output logic sync_reset_n
);
    // ==========================================
    // Synchroniser stages
    logic meta_ff; // First stage, read only by second
    logic hold_ff; // Second stage

    // Assert asynchronously, release after two edges
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else begin
            meta_ff <= 1'b1;
            hold_ff <= meta_ff;
        end
    end

    assign sync_reset_n = hold_ff;
endmodule : pmc_reset_sync

// ==== logic/pmc_wake_edge.sv ====
// Falling edge detector for the comparator wake input
`timescale 1ns/100ps
module pmc_wake_edge (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic level_in,
    output logic fall_pulse
);
    // ==========================================
    // Previous level register
    logic prev_ff; // Last sampled level
    logic nxt_prev; // Next level

    // Next value
    always_comb begin
        nxt_prev = level_in;
    end

    // Register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= nxt_prev;
        end
    end

    // One-cycle pulse on a high-to-low change
    assign fall_pulse = prev_ff & ~level_in;
endmodule : pmc_wake_edge

// ==== logic/power_mode_controller.sv ====
// Power mode controller: sequences clocks, oscillators and regulator bias
// ==========================================
// Summary of operation
// - Gate clocks of disabled digital peripherals
// - Idle bit halts core, peripherals run
// - Any interrupt wakes idle to execution
// - Suspend stops clocks, both fast oscillators
// - Suspend keeps normal bias, wakes on event
// - Snooze stops clocks, oscillators, wakes on event
// - Snooze switches regulator to low bias
// - Timers 3, 4 may run slowly
// - Six wake sources end suspend, snooze
// - Stop bit powers down; depth selects kind
// - Stop leaves only through any reset
// - Shutdown leaves on pin, power-on reset
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "pmc_defs.svh"
module power_mode_controller #(
    parameter int PERIPH_N = `PMC_PERIPH_N
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire pmc_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic irq_pending,
    input wire pmc_pkg::wake_src_t wake_src,
    input wire logic comparator0_out,
    input wire logic external_reset_pin_n,
    input wire logic power_on_reset,
    input wire logic other_reset,
    output pmc_pkg::power_ctrl_t power_ctrl,
    output logic [PERIPH_N-1:0] periph_clk_gate,
    output logic [1:0] system_clock_sel,
    output logic reset_request,
    output pmc_pkg::power_mode_t power_mode
);
    import pmc_pkg::*;

    // ==========================================
    // Reset and edge detection
    logic rst_n; // Synchronised reset
    logic cmp0_fall; // Comparator falling edge pulse

    pmc_reset_sync u_reset_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .sync_reset_n(rst_n)
    );

    pmc_wake_edge u_wake_edge (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .level_in(comparator0_out),
        .fall_pulse(cmp0_fall)
    );

    // ==========================================
    // Registers
    logic [1:0] primary_ff; // Power control primary bits
    logic [1:0] secondary_ff; // Power control secondary bits
    logic [7:0] regulator_ff; // Regulator control
    logic [PERIPH_N-1:0] periph_en_ff; // Peripheral enables
    logic [1:0] clock_src_ff; // System clock selection
    logic [7:0] rdata_ff; // Read data
    power_mode_t mode_ff; // Current power mode
    logic rst_req_ff; // Reset request to the reset network
    logic [1:0] nxt_primary;
    logic [1:0] nxt_secondary;
    logic [7:0] nxt_regulator;
    logic [PERIPH_N-1:0] nxt_periph_en;
    logic [1:0] nxt_clock_src;
    logic [7:0] nxt_rdata;
    power_mode_t nxt_mode;
    logic nxt_rst_req;
    logic wake_any; // Any suspend or snooze wake
    logic wr_hit; // Write decode helper
    logic depth_sel; // Power down depth select

    // Write decode
    function automatic logic is_wr(input reg_req_t r, input logic [3:0] off);
        is_wr = r.wr && (r.addr == off);
    endfunction : is_wr

    assign depth_sel = regulator_ff[`PMC_BIT_DEPTH];
    assign wr_hit = reg_req.wr;

    // Wake sources, comparator taken from its falling edge
    always_comb begin
        wake_any = wake_src.timer4_event | wake_src.spi_activity
                 | wake_src.i2c_target_activity | wake_src.port_match
                 | wake_src.comparator0_fall | cmp0_fall | wake_src.clu_event;
    end

    // ==========================================
    // Register and mode next-state logic
    always_comb begin
        nxt_primary = primary_ff;
        nxt_secondary = secondary_ff;
        nxt_regulator = regulator_ff;
        nxt_periph_en = periph_en_ff;
        nxt_clock_src = clock_src_ff;
        nxt_mode = mode_ff;
        nxt_rst_req = 1'b0;
        nxt_rdata = 8'h00;
        // Software writes, only honoured while the core runs
        if (mode_ff == MODE_NORMAL && wr_hit) begin
            if (is_wr(reg_req, `PMC_OFF_REGULATOR)) begin
                nxt_regulator = reg_req.wdata;
            end
            if (is_wr(reg_req, `PMC_OFF_PERIPH_EN)) begin
                nxt_periph_en = reg_req.wdata[PERIPH_N-1:0];
            end
            if (is_wr(reg_req, `PMC_OFF_CLOCK_SRC)) begin
                nxt_clock_src = reg_req.wdata[1:0];
            end
            if (is_wr(reg_req, `PMC_OFF_PRIMARY)) begin
                // Stop outranks idle; one mode at a time
                if (reg_req.wdata[`PMC_BIT_STOP]) begin
                    nxt_mode = depth_sel ? MODE_SHUTDOWN : MODE_STOP;
                    nxt_primary = 2'b10;
                end else if (reg_req.wdata[`PMC_BIT_IDLE]) begin
                    nxt_mode = MODE_IDLE;
                    nxt_primary = 2'b01;
                end
            end
            if (is_wr(reg_req, `PMC_OFF_SECONDARY)) begin
                // Suspend outranks snooze
                if (reg_req.wdata[`PMC_BIT_SUSPEND]) begin
                    nxt_mode = MODE_SUSPEND;
                    nxt_secondary = 2'b01;
                end else if (reg_req.wdata[`PMC_BIT_SNOOZE]) begin
                    nxt_mode = MODE_SNOOZE;
                    nxt_secondary = 2'b10;
                end
            end
        end
        // Mode exits
        case (mode_ff)
            MODE_NORMAL: begin
                // Nothing to leave
            end
            MODE_IDLE: begin
                if (irq_pending) begin
                    nxt_mode = MODE_NORMAL;
                    nxt_primary = 2'b00;
                end
            end
            MODE_SUSPEND, MODE_SNOOZE: begin
                if (wake_any) begin
                    nxt_mode = MODE_NORMAL;
                    nxt_secondary = 2'b00;
                end
            end
            MODE_STOP: begin
                // Any reset source asks the reset network to restart
                nxt_rst_req = ~external_reset_pin_n | power_on_reset | other_reset;
            end
            MODE_SHUTDOWN: begin
                // Only pin or power-on reset
                nxt_rst_req = ~external_reset_pin_n | power_on_reset;
            end
            default: begin
                nxt_mode = MODE_NORMAL;
            end
        endcase
        // Read data, one cycle later
        if (reg_req.rd) begin
            case (reg_req.addr)
                `PMC_OFF_PRIMARY: nxt_rdata = {6'h00, primary_ff};
                `PMC_OFF_SECONDARY: nxt_rdata = {6'h00, secondary_ff};
                `PMC_OFF_REGULATOR: nxt_rdata = regulator_ff;
                `PMC_OFF_PERIPH_EN: nxt_rdata = 8'(periph_en_ff);
                `PMC_OFF_STATUS: nxt_rdata = {5'h00, mode_ff};
                `PMC_OFF_CLOCK_SRC: nxt_rdata = {6'h00, clock_src_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // Register update
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            primary_ff <= 2'h0;
            secondary_ff <= 2'h0;
            regulator_ff <= `PMC_RST_REGULATOR;
            periph_en_ff <= PERIPH_N'(`PMC_RST_PERIPH_EN);
            clock_src_ff <= `PMC_SRC_FAST_A;
            rdata_ff <= 8'h00;
            mode_ff <= MODE_NORMAL;
            rst_req_ff <= 1'b0;
        end else begin
            primary_ff <= nxt_primary;
            secondary_ff <= nxt_secondary;
            regulator_ff <= nxt_regulator;
            periph_en_ff <= nxt_periph_en;
            clock_src_ff <= nxt_clock_src;
            rdata_ff <= nxt_rdata;
            mode_ff <= nxt_mode;
            rst_req_ff <= nxt_rst_req;
        end
    end

    // ==========================================
    // Clock, oscillator and regulator outputs
    always_comb begin
        power_ctrl.core_clk_en = (mode_ff == MODE_NORMAL);
        power_ctrl.periph_clk_en = (mode_ff == MODE_NORMAL) || (mode_ff == MODE_IDLE);
        power_ctrl.fast_oscillator_a_en = (mode_ff == MODE_NORMAL) || (mode_ff == MODE_IDLE);
        power_ctrl.fast_oscillator_b_en = (mode_ff == MODE_NORMAL) || (mode_ff == MODE_IDLE);
        // Slow timers only in suspend or snooze
        power_ctrl.slow_t3_en = (mode_ff == MODE_SUSPEND || mode_ff == MODE_SNOOZE)
                              && regulator_ff[`PMC_BIT_SLOW_T3];
        power_ctrl.slow_t4_en = (mode_ff == MODE_SUSPEND || mode_ff == MODE_SNOOZE)
                              && regulator_ff[`PMC_BIT_SLOW_T4];
        power_ctrl.reg_low_bias = (mode_ff == MODE_SNOOZE);
        power_ctrl.power_nets_off = (mode_ff == MODE_STOP) || (mode_ff == MODE_SHUTDOWN);
    end

    // Per-peripheral gate: enabled and the peripheral clock running
    assign periph_clk_gate = periph_en_ff & {PERIPH_N{power_ctrl.periph_clk_en}};
    assign system_clock_sel = clock_src_ff;
    assign reset_request = rst_req_ff;
    assign power_mode = mode_ff;
    assign reg_rdata = rdata_ff;

    // ==========================================
    // Checks
    a_idle_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode_ff == MODE_NORMAL && is_wr(reg_req, `PMC_OFF_PRIMARY) && reg_req.wdata == 8'h01)
        |=> (power_mode == MODE_IDLE && !power_ctrl.core_clk_en && power_ctrl.periph_clk_en))
        else $error("idle entry wrong");
    a_idle_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode_ff == MODE_IDLE && irq_pending) |=> (power_mode == MODE_NORMAL && power_ctrl.core_clk_en))
        else $error("idle wake wrong");
    a_suspend_clocks: assert property (@(posedge core_clk) disable iff (!rst_n)
        (power_mode == MODE_SUSPEND) |-> (!power_ctrl.periph_clk_en && !power_ctrl.fast_oscillator_a_en
        && !power_ctrl.fast_oscillator_b_en && !power_ctrl.reg_low_bias))
        else $error("suspend controls wrong");
    a_snooze_bias: assert property (@(posedge core_clk) disable iff (!rst_n)
        (power_mode == MODE_SNOOZE) |-> (power_ctrl.reg_low_bias && !power_ctrl.core_clk_en))
        else $error("snooze bias wrong");
    a_sleep_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
        ((mode_ff == MODE_SUSPEND || mode_ff == MODE_SNOOZE) && wake_src.spi_activity)
        |=> (power_mode == MODE_NORMAL))
        else $error("sleep wake wrong");
    a_stop_held: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode_ff == MODE_STOP) |=> (power_mode == MODE_STOP && power_ctrl.power_nets_off))
        else $error("stop left without reset");
    a_shutdown_exit: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode_ff == MODE_SHUTDOWN && external_reset_pin_n && !power_on_reset) |=> !reset_request)
        else $error("shutdown woke wrongly");
    a_gate_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        periph_clk_gate == (((mode_ff == MODE_NORMAL) || (mode_ff == MODE_IDLE)) ? periph_en_ff : '0))
        else $error("peripheral clock gate wrong");
    // Snooze stops the same clocks as suspend
    a_snooze_clocks: assert property (@(posedge core_clk) disable iff (!rst_n)
        (power_mode == MODE_SNOOZE) |-> (!power_ctrl.periph_clk_en && !power_ctrl.fast_oscillator_a_en
        && !power_ctrl.fast_oscillator_b_en))
        else $error("snooze controls wrong");
    // Suspend request taken from a running core
    a_suspend_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode_ff == MODE_NORMAL && is_wr(reg_req, `PMC_OFF_SECONDARY) && reg_req.wdata[`PMC_BIT_SUSPEND])
        |=> (power_mode == MODE_SUSPEND))
        else $error("suspend entry wrong");
    // Snooze request without suspend beside it
    a_snooze_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode_ff == MODE_NORMAL && is_wr(reg_req, `PMC_OFF_SECONDARY) && reg_req.wdata[`PMC_BIT_SNOOZE]
        && !reg_req.wdata[`PMC_BIT_SUSPEND]) |=> (power_mode == MODE_SNOOZE))
        else $error("snooze entry wrong");
    // Stop bit with a clear depth select enters stop
    a_stop_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode_ff == MODE_NORMAL && is_wr(reg_req, `PMC_OFF_PRIMARY) && reg_req.wdata[`PMC_BIT_STOP]
        && !regulator_ff[`PMC_BIT_DEPTH]) |=> (power_mode == MODE_STOP && power_ctrl.power_nets_off))
        else $error("stop entry wrong");
    // Stop bit with depth select set enters shutdown
    a_shutdown_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode_ff == MODE_NORMAL && is_wr(reg_req, `PMC_OFF_PRIMARY) && reg_req.wdata[`PMC_BIT_STOP]
        && regulator_ff[`PMC_BIT_DEPTH]) |=> (power_mode == MODE_SHUTDOWN && power_ctrl.power_nets_off))
        else $error("shutdown entry wrong");
    // Any reset source asks for a restart from stop
    a_stop_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode_ff == MODE_STOP && (other_reset || power_on_reset || !external_reset_pin_n)) |=> reset_request)
        else $error("stop reset not requested");
    // Pin or power-on reset wakes shutdown
    a_shutdown_pin: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode_ff == MODE_SHUTDOWN && (!external_reset_pin_n || power_on_reset)) |=> reset_request)
        else $error("shutdown reset not requested");
    // Slow timer clocks only while asleep
    a_slow_timers: assert property (@(posedge core_clk) disable iff (!rst_n)
        (power_mode != MODE_SUSPEND && power_mode != MODE_SNOOZE)
        |-> (!power_ctrl.slow_t3_en && !power_ctrl.slow_t4_en))
        else $error("slow timer clock wrong");
    // Any of the six wake sources ends suspend or snooze
    a_sleep_wake_any: assert property (@(posedge core_clk) disable iff (!rst_n)
        ((mode_ff == MODE_SUSPEND || mode_ff == MODE_SNOOZE) && (wake_src != '0 || cmp0_fall))
        |=> (power_mode == MODE_NORMAL && power_ctrl.core_clk_en))
        else $error("sleep wake source ignored");
    // Idle keeps peripherals and oscillators running
    a_idle_periph: assert property (@(posedge core_clk) disable iff (!rst_n)
        (power_mode == MODE_IDLE) |-> (power_ctrl.periph_clk_en && power_ctrl.fast_oscillator_a_en
        && power_ctrl.fast_oscillator_b_en && !power_ctrl.core_clk_en))
        else $error("idle controls wrong");
    // A halted core cannot start a second mode
    a_one_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode_ff == MODE_IDLE && !irq_pending && reg_req.wr) |=> (power_mode == MODE_IDLE))
        else $error("second mode started");
endmodule : power_mode_controller
